//--- rtl/hfm_pkg.sv
// Shared constants for the two-controller HDLC FIFO and mapping block.
// Assumes one framer clock domain and a byte-wide host register port.
package hfm_pkg;

  // Structure sizes
  localparam int CTRL_N = 2;
  localparam int FIFO_BYTES = 128;
  localparam int RX_BUF_WORDS = 4;
  localparam int ADDR_W = 6;
  localparam int LEN_W = 12;

  // Register offsets inside one controller window
  localparam logic [4:0] OFS_TX_CTL = 5'h00;
  localparam logic [4:0] OFS_RX_CTL = 5'h01;
  localparam logic [4:0] OFS_WM = 5'h02;
  localparam logic [4:0] OFS_STATUS = 5'h03;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_INFO = 5'h05;
  localparam logic [4:0] OFS_RX_PBC = 5'h06;
  localparam logic [4:0] OFS_TX_SPACE = 5'h07;
  localparam logic [2:0] GRP_RX_CS = 3'h2;
  localparam logic [2:0] GRP_TX_CS = 3'h3;
  localparam logic [4:0] OFS_RX_BS = 5'h10;
  localparam logic [4:0] OFS_TX_BS = 5'h11;
  localparam logic [4:0] OFS_RX_FIFO = 5'h12;
  localparam logic [4:0] OFS_TX_FIFO = 5'h13;
  localparam int CTRL_SEL_BIT = 5;

  // Field positions
  localparam int CTL_RESET_BIT = 0;
  localparam int CTL_MAP_LSB = 1;
  localparam int WM_RX_LSB = 0;
  localparam int WM_TX_LSB = 3;
  localparam int WM_SHIFT = 4;
  localparam int ST_TX_LOW_MARK_FLAG_BIT = 0;
  localparam int ST_RX_HIGH_MARK_FLAG_BIT = 1;
  localparam int ST_RPE_BIT = 2;
  localparam int PBC_MSB = 7;

  // Packet state codes
  localparam logic [2:0] PS_RUN = 3'h0;
  localparam logic [2:0] PS_GOOD = 3'h1;
  localparam logic [2:0] PS_CRC = 3'h2;
  localparam logic [2:0] PS_ABORT = 3'h3;
  localparam logic [2:0] PS_OVF = 3'h4;

  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic RST_INT_N = 1'b1;
  localparam logic RST_READY = 1'b1;

  // Bandwidth mapping modes
  typedef enum logic [1:0] {HFM_MAP_OFF, HFM_MAP_FDL, HFM_MAP_SA, HFM_MAP_CHAN} hfm_map_e;

endpackage

//--- rtl/hfm_fifo.sv
// Synchronous FIFO with registered show-ahead read data and flush.
// Assumes one clock; DEPTH must be a power of two.
`timescale 1ns/100ps
module hfm_fifo import hfm_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Entries held, output register included
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  // Refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hfm_fifo DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] mcnt;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
    logic in_ready;
    logic [CW-1:0] level;
  } hfm_fifo_state_s;

  hfm_fifo_state_s s;
  hfm_fifo_state_s next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  logic load;

  // Handshakes and refill of the output register
  assign push = in_valid & s.in_ready;
  assign pop = s.out_valid & out_ready;
  assign load = (s.mcnt != '0) & (~s.out_valid | pop);

  // Next pointers, counts and output word
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = PW'(s.wp + 1'b1);
    end
    if (load) begin
      next_s.rp = PW'(s.rp + 1'b1);
      next_s.out_data = mem[s.rp];
      next_s.out_valid = 1'b1;
    end else if (pop) begin
      next_s.out_valid = 1'b0;
    end
    next_s.mcnt = CW'(s.mcnt + CW'(push) - CW'(load));
    next_s.level = CW'(next_s.mcnt + CW'(next_s.out_valid));
    next_s.in_ready = (next_s.level < CW'(DEPTH));
    if (flush) begin
      next_s = '0;
      next_s.in_ready = RST_READY;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.in_ready <= RST_READY;
    end else begin
      s <= next_s;
    end
  end

  // Storage array
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end

  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data = s.out_data;
  assign level = s.level;

  // Back-pressure only when truly full
  fifo_full_a: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
    !in_ready |-> level == CW'(DEPTH))
    else $error("fifo refuses data while not full");

endmodule // hfm_fifo

//--- rtl/hfm_top.sv
// Two HDLC controllers: host FIFO access, watermarks, mapping, packet status.
// Assumes framing engines and framer slot timing share mclk with the host port.
// Overview of operation
// RQ1: Each controller gives the host byte access to its 128-byte receive FIFO.
// RQ2: Each controller gives the host byte access to its 128-byte transmit FIFO.
// RQ3: Watermark register bits 5:3 hold transmit low mark, bits 2:0 receive high mark.
// RQ4: Transmit low-mark flag is live while the transmit FIFO sits below its mark.
// RQ5: Receive high-mark flag is live while the receive FIFO sits above its mark.
// RQ6: An enabled watermark flag pulls the active-low interrupt output.
// RQ7: The interrupt mask selects bit by bit which status flags raise the interrupt.
// RQ8: Each controller maps to facility link, Sa bits or channels, both directions.
// RQ9: Any channel set is allowed; a bit-select register chooses used bits.
// RQ10: Four receive channel selects cover channels 1-8, 9-16, 17-24, 25-32.
// RQ11: Four transmit channel selects cover the same eight-channel groups.
// RQ12: Transmit space register reports bytes writable without overflow.
// RQ13: Packet byte count low seven bits give readable bytes up to message end.
// RQ14: Count MSB reads 1 while the counted bytes belong to an unfinished packet.
// RQ15: Packet state code: 000 running, 001 good, 010 CRC, 011 abort, 100 overflow.
// RQ16: Host resets, configures, enables interrupts, then reads count and bytes.
// RQ17: Host reads the state code after draining and restarts its buffer.
// RQ18: Software never maps both transmit controllers onto the same bandwidth.
// RQ19: Framing engines do flags, CRC, aborts, zero stuffing and byte alignment.
// RQ20: Control registers select CRC, stuffing, mapping, idle and controller reset.
// RQ21: Each receive port read pops a byte, each transmit port write pushes one.
// RQ22: Channel-select bit n enables the nth channel of its group, bit 0 lowest.
`timescale 1ns/100ps
module hfm_top import hfm_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_BYTES,
  parameter int BUF_DEPTH = RX_BUF_WORDS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic int_n,
  // Framer slot position
  input wire logic [4:0] slot_chan,
  input wire logic [2:0] slot_bit,
  input wire logic slot_is_fdl,
  input wire logic slot_is_sa,
  input wire logic [2:0] slot_sa_idx,
  // Bandwidth strobes per controller
  output logic [1:0] tx_take,
  output logic [1:0] rx_take,
  // Configuration to framing engines
  output logic [1:0][7:0] tx_config,
  output logic [1:0][7:0] rx_config,
  // Transmit bytes to framing engines
  output logic [1:0] tx_byte_valid,
  output logic [1:0][7:0] tx_byte_data,
  input wire logic [1:0] tx_byte_ready,
  // Receive bytes from framing engines
  input wire logic [1:0] rx_byte_valid,
  input wire logic [1:0][7:0] rx_byte_data,
  input wire logic [1:0] rx_byte_end,
  input wire logic [1:0][2:0] rx_end_code,
  output logic [1:0] rx_byte_ready
);
  localparam int LVL_W = $clog2(FIFO_DEPTH+1);

  // Refuse sizes the byte-wide registers cannot report
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255 || BUF_DEPTH < 2) begin : g_bad_size
    $error("hfm_top FIFO_DEPTH must be 2..255 and BUF_DEPTH at least 2");
  end

  typedef struct packed {
    logic [1:0][7:0] tx_ctl;
    logic [1:0][7:0] rx_ctl;
    logic [1:0][7:0] wm;
    logic [1:0][7:0] mask;
    logic [1:0][3:0][7:0] rx_cs;
    logic [1:0][3:0][7:0] tx_cs;
    logic [1:0][7:0] rx_bs;
    logic [1:0][7:0] tx_bs;
    logic [1:0] pkt_end;
    logic [1:0][2:0] code;
    logic [1:0][LEN_W-1:0] rd_in_pkt;
    logic [1:0][LEN_W-1:0] wr_pkt_len;
    logic [1:0] tx_take;
    logic [1:0] rx_take;
    logic [7:0] rdata;
    logic int_n;
  } hfm_state_s;

  hfm_state_s s;
  hfm_state_s next_s;

  // Per-controller datapath wires
  logic [1:0] buf_v;
  logic [1:0] buf_r;
  logic [1:0][11:0] buf_d;
  logic [1:0] rxf_in_v;
  logic [1:0] rxf_in_r;
  logic [1:0] rxf_v;
  logic [1:0][8:0] rxf_d;
  logic [1:0][LVL_W-1:0] rxf_lvl;
  logic [1:0] lq_in_v;
  logic [1:0] lq_in_r;
  logic [1:0] lq_v;
  logic [1:0][LEN_W+2:0] lq_d;
  logic [1:0] txf_in_r;
  logic [1:0][LVL_W-1:0] txf_lvl;
  logic [1:0] rx_pop;
  logic [1:0] rx_pop_end;
  logic [1:0] tx_push;
  logic [1:0] tx_low_mark_flag;
  logic [1:0] rx_high_mark_flag;
  logic [1:0][7:0] stat;
  logic [1:0][7:0] pbc;
  logic [1:0] tx_flush;
  logic [1:0] rx_flush;
  logic sel;
  logic [4:0] ofs;

  // Clamp a length to the seven-bit count field
  function automatic logic [6:0] sat7(input logic [LEN_W-1:0] v);
    return (v > LEN_W'(127)) ? 7'h7F : v[6:0];
  endfunction

  // Watermark code to a byte threshold
  function automatic logic [LVL_W-1:0] wm_bytes(input logic [2:0] code);
    return LVL_W'({code, 4'h0}) >> (4 - WM_SHIFT);
  endfunction

  // Whether the current slot bit belongs to a controller
  function automatic logic map_take(input logic [1:0] mode, input logic [3:0][7:0] cs,
                                    input logic [7:0] bs, input logic [4:0] ch,
                                    input logic [2:0] bt, input logic facility_link_bits, input logic sa,
                                    input logic [2:0] sa_i);
    logic hit;
    hit = 1'b0;
    case (mode)
      HFM_MAP_FDL: begin
        hit = facility_link_bits;
      end
      HFM_MAP_SA: begin
        hit = sa & bs[sa_i];
      end
      HFM_MAP_CHAN: begin
        hit = cs[ch[4:3]][ch[2:0]] & bs[bt];
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Host address split
  assign sel = reg_addr[CTRL_SEL_BIT];
  assign ofs = reg_addr[4:0];

  for (genvar k = 0; k < CTRL_N; k++) begin : g_ctrl
    // Port strobes and live flags
    assign rx_pop[k] = reg_rd & (sel == 1'(k)) & (ofs == OFS_RX_FIFO) & rxf_v[k]; // [RQ21]
    assign rx_pop_end[k] = rx_pop[k] & rxf_d[k][8];
    assign tx_push[k] = reg_wr & (sel == 1'(k)) & (ofs == OFS_TX_FIFO); // [RQ21]
    assign tx_low_mark_flag[k] = txf_lvl[k] < wm_bytes(s.wm[k][WM_TX_LSB +: 3]); // [RQ3] [RQ4]
    assign rx_high_mark_flag[k] = rxf_lvl[k] > wm_bytes(s.wm[k][WM_RX_LSB +: 3]); // [RQ3] [RQ5]
    assign stat[k] = {5'h00, s.pkt_end[k], rx_high_mark_flag[k], tx_low_mark_flag[k]};
    assign tx_flush[k] = s.tx_ctl[k][CTL_RESET_BIT]; // [RQ20]
    assign rx_flush[k] = s.rx_ctl[k][CTL_RESET_BIT]; // [RQ20]

    // Bytes up to the end of the head message, MSB set while unfinished
    assign pbc[k] = lq_v[k] ? {1'b0, sat7(LEN_W'(lq_d[k][LEN_W-1:0] - s.rd_in_pkt[k]))}
                            : {1'b1, sat7(LEN_W'(rxf_lvl[k]))}; // [RQ13] [RQ14]

    // Receive bytes move from the small buffer when the receive FIFO accepts, end bytes only when both queues accept
    assign rxf_in_v[k] = buf_v[k] & (~buf_d[k][8] | lq_in_r[k]);
    assign lq_in_v[k] = buf_v[k] & buf_d[k][8] & rxf_in_r[k];
    assign buf_r[k] = rxf_in_r[k] & (~buf_d[k][8] | lq_in_r[k]);

    // Elastic buffer between framing engine and receive FIFO
    hfm_fifo #(.WIDTH(12), .DEPTH(BUF_DEPTH)) u_rx_buf ( // [RQ19]
      .mclk(mclk), .rst(rst), .flush(rx_flush[k]),
      .in_valid(rx_byte_valid[k]), .in_ready(rx_byte_ready[k]),
      .in_data({rx_end_code[k], rx_byte_end[k], rx_byte_data[k]}),
      .out_valid(buf_v[k]), .out_ready(buf_r[k]), .out_data(buf_d[k]), .level()
    );

    // Receive FIFO, data with end-of-message marker
    hfm_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo ( // [RQ1]
      .mclk(mclk), .rst(rst), .flush(rx_flush[k]),
      .in_valid(rxf_in_v[k]), .in_ready(rxf_in_r[k]), .in_data(buf_d[k][8:0]),
      .out_valid(rxf_v[k]), .out_ready(rx_pop[k]), .out_data(rxf_d[k]), .level(rxf_lvl[k])
    );

    // Message length and end code queue
    hfm_fifo #(.WIDTH(LEN_W+3), .DEPTH(FIFO_DEPTH)) u_len_q (
      .mclk(mclk), .rst(rst), .flush(rx_flush[k]),
      .in_valid(lq_in_v[k]), .in_ready(lq_in_r[k]),
      .in_data({buf_d[k][11:9], LEN_W'(s.wr_pkt_len[k] + 1'b1)}),
      .out_valid(lq_v[k]), .out_ready(rx_pop_end[k]), .out_data(lq_d[k]), .level()
    );

    // Transmit FIFO toward the framing engine
    hfm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo ( // [RQ2]
      .mclk(mclk), .rst(rst), .flush(tx_flush[k]),
      .in_valid(tx_push[k]), .in_ready(txf_in_r[k]), .in_data(reg_wdata),
      .out_valid(tx_byte_valid[k]), .out_ready(tx_byte_ready[k]),
      .out_data(tx_byte_data[k]), .level(txf_lvl[k])
    );
  end

  // Register writes, packet tracking, mapping strobes and read data
  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    for (int k = 0; k < CTRL_N; k++) begin
      // Controller resets clear themselves after one cycle
      next_s.tx_ctl[k][CTL_RESET_BIT] = 1'b0;
      next_s.rx_ctl[k][CTL_RESET_BIT] = 1'b0;
      // Length of the message being written
      if (buf_v[k] & buf_r[k]) begin
        next_s.wr_pkt_len[k] = buf_d[k][8] ? '0 : LEN_W'(s.wr_pkt_len[k] + 1'b1);
      end
      // Host pops: track position and latch the end code
      if (rx_pop[k]) begin
        next_s.rd_in_pkt[k] = rx_pop_end[k] ? '0 : LEN_W'(s.rd_in_pkt[k] + 1'b1);
        next_s.code[k] = rx_pop_end[k] ? lq_d[k][LEN_W +: 3] : PS_RUN; // [RQ15]
      end
      if (rx_flush[k]) begin
        next_s.wr_pkt_len[k] = '0;
        next_s.rd_in_pkt[k] = '0;
        next_s.code[k] = PS_RUN;
      end
      // Mapping onto the current slot bit
      next_s.tx_take[k] = map_take(s.tx_ctl[k][CTL_MAP_LSB +: 2], s.tx_cs[k], s.tx_bs[k],
                                   slot_chan, slot_bit, slot_is_fdl, slot_is_sa,
                                   slot_sa_idx); // [RQ8] [RQ9] [RQ11] [RQ22]
      next_s.rx_take[k] = map_take(s.rx_ctl[k][CTL_MAP_LSB +: 2], s.rx_cs[k], s.rx_bs[k],
                                   slot_chan, slot_bit, slot_is_fdl, slot_is_sa,
                                   slot_sa_idx); // [RQ8] [RQ9] [RQ10] [RQ22]
    end
    // Host writes
    if (reg_wr) begin
      if (ofs[4:2] == GRP_RX_CS) begin
        next_s.rx_cs[sel][ofs[1:0]] = reg_wdata; // [RQ10]
      end else if (ofs[4:2] == GRP_TX_CS) begin
        next_s.tx_cs[sel][ofs[1:0]] = reg_wdata; // [RQ11]
      end else begin
        case (ofs)
          OFS_TX_CTL: next_s.tx_ctl[sel] = reg_wdata; // [RQ20]
          OFS_RX_CTL: next_s.rx_ctl[sel] = reg_wdata; // [RQ20]
          OFS_WM: next_s.wm[sel] = {2'b00, reg_wdata[5:0]}; // [RQ3]
          OFS_MASK: next_s.mask[sel] = reg_wdata; // [RQ7]
          OFS_RX_BS: next_s.rx_bs[sel] = reg_wdata; // [RQ9]
          OFS_TX_BS: next_s.tx_bs[sel] = reg_wdata; // [RQ9]
          default: begin
          end
        endcase
      end
    end
    // Host reads
    if (reg_rd) begin
      if (ofs[4:2] == GRP_RX_CS) begin
        next_s.rdata = s.rx_cs[sel][ofs[1:0]];
      end else if (ofs[4:2] == GRP_TX_CS) begin
        next_s.rdata = s.tx_cs[sel][ofs[1:0]];
      end else begin
        case (ofs)
          OFS_TX_CTL: next_s.rdata = s.tx_ctl[sel];
          OFS_RX_CTL: next_s.rdata = s.rx_ctl[sel];
          OFS_WM: next_s.rdata = s.wm[sel];
          OFS_STATUS: next_s.rdata = stat[sel];
          OFS_MASK: next_s.rdata = s.mask[sel];
          OFS_INFO: next_s.rdata = {5'h00, s.code[sel]}; // [RQ15]
          OFS_RX_PBC: next_s.rdata = pbc[sel]; // [RQ13] [RQ14]
          OFS_TX_SPACE: next_s.rdata = 8'(FIFO_DEPTH - int'(txf_lvl[sel])); // [RQ12]
          OFS_RX_BS: next_s.rdata = s.rx_bs[sel];
          OFS_TX_BS: next_s.rdata = s.tx_bs[sel];
          OFS_RX_FIFO: next_s.rdata = rxf_v[sel] ? rxf_d[sel][7:0] : 8'h00; // [RQ1]
          default: next_s.rdata = 8'h00;
        endcase
      end
    end
    // Sticky end-of-message flag: read clears, a new end wins
    for (int k = 0; k < CTRL_N; k++) begin
      if (reg_rd & (sel == 1'(k)) & (ofs == OFS_STATUS)) begin
        next_s.pkt_end[k] = 1'b0;
      end
      if (rx_pop_end[k]) begin
        next_s.pkt_end[k] = 1'b1;
      end
    end
    // Masked status drives the shared interrupt
    next_s.int_n = ~(|(stat[0] & s.mask[0]) | |(stat[1] & s.mask[1])); // [RQ6] [RQ7]
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.int_n <= RST_INT_N;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign int_n = s.int_n;
  assign tx_take = s.tx_take;
  assign rx_take = s.rx_take;
  assign tx_config = s.tx_ctl;
  assign rx_config = s.rx_ctl;

  // Receive pop removes exactly one byte
  rx_pop_count_a: assert property (@(posedge mclk) disable iff (rst) // [RQ21]
    (rx_pop[0] && !rxf_in_v[0] && !rx_flush[0]) |=> rxf_lvl[0] == $past(rxf_lvl[0]) - 1'b1)
    else $error("receive pop did not remove one byte");

  // Transmit write adds exactly one byte
  tx_push_count_a: assert property (@(posedge mclk) disable iff (rst) // [RQ21]
    (tx_push[0] && txf_in_r[0] && !(tx_byte_valid[0] && tx_byte_ready[0]) && !tx_flush[0])
    |=> txf_lvl[0] == $past(txf_lvl[0]) + 1'b1)
    else $error("transmit write did not add one byte");

  // Enabled low-mark flag pulls the interrupt
  int_low_a: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
    (tx_low_mark_flag[0] && s.mask[0][ST_TX_LOW_MARK_FLAG_BIT]) |=> !int_n)
    else $error("enabled watermark did not raise interrupt");

  // Masked-off flags keep the interrupt idle
  int_gate_a: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
    (s.mask == '0) |=> int_n)
    else $error("interrupt raised with all flags masked");

  // Unfinished message reports MSB set
  pbc_msb_a: assert property (@(posedge mclk) disable iff (rst) // [RQ14]
    (reg_rd && ofs == OFS_RX_PBC && !lq_v[sel]) |=> reg_rdata[PBC_MSB])
    else $error("count MSB clear for unfinished packet");

  // End byte pop latches the queued end code
  info_code_a: assert property (@(posedge mclk) disable iff (rst) // [RQ15]
    (rx_pop_end[0] && !rx_flush[0]) |=> s.code[0] == $past(lq_d[0][LEN_W +: 3]))
    else $error("packet state code not taken from message end");

  // Space register mirrors free transmit entries
  tx_space_a: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
    (reg_rd && ofs == OFS_TX_SPACE) |=> reg_rdata == 8'(FIFO_DEPTH - int'($past(txf_lvl[sel]))))
    else $error("transmit space reading wrong");

  // Channel mapping raises the receive strobe
  rx_map_a: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
    (s.rx_ctl[0][CTL_MAP_LSB +: 2] == HFM_MAP_CHAN && s.rx_cs[0][slot_chan[4:3]][slot_chan[2:0]]
     && s.rx_bs[0][slot_bit]) |=> rx_take[0])
    else $error("mapped channel bit not taken");

  // Controller reset empties the transmit FIFO
  tx_reset_a: assert property (@(posedge mclk) disable iff (rst) // [RQ20]
    (reg_wr && sel == 1'b0 && ofs == OFS_TX_CTL && reg_wdata[CTL_RESET_BIT])
    |=> ##1 txf_lvl[0] == '0)
    else $error("controller reset did not flush transmit FIFO");

endmodule // hfm_top

//--- test/hfm_engine_model.sv
// Framing-engine stand-in: feeds receive bytes and sinks transmit bytes.
// Assumes the bench calls send() and drives stall at the falling edge.
`timescale 1ns/100ps
module hfm_engine_model (
  // Clock and sink control
  input wire logic mclk,
  input wire logic stall,
  // Transmit bytes
  input wire logic [1:0] tx_byte_valid,
  input wire logic [1:0][7:0] tx_byte_data,
  output logic [1:0] tx_byte_ready,
  // Receive bytes
  output logic [1:0] rx_byte_valid,
  output logic [1:0][7:0] rx_byte_data,
  output logic [1:0] rx_byte_end,
  output logic [1:0][2:0] rx_end_code,
  input wire logic [1:0] rx_byte_ready
);
  logic [7:0] tx_seen[$];
  // Sink stalls on request
  assign tx_byte_ready = {2{~stall}};
  // Collect bytes of the first controller, index 0, in order
  always @(posedge mclk) begin
    if (tx_byte_valid[0] && tx_byte_ready[0]) begin
      tx_seen.push_back(tx_byte_data[0]);
    end
  end
  // Idle with scrambled data so a stale byte never matches
  initial begin
    rx_byte_valid = 2'h0;
    rx_byte_data = 16'hA55A;
    rx_byte_end = 2'h0;
    rx_end_code = 6'h2D;
  end
  // Offer one byte and hold it until taken
  task automatic send(input int c, input logic [7:0] d, input logic e, input logic [2:0] k);
    @(negedge mclk);
    rx_byte_valid[c] = 1'b1;
    rx_byte_data[c] = d;
    rx_byte_end[c] = e;
    rx_end_code[c] = k;
    @(posedge mclk);
    while (!rx_byte_ready[c]) @(posedge mclk);
    @(negedge mclk);
    rx_byte_valid[c] = 1'b0;
    rx_byte_data[c] = ~d;
    rx_end_code[c] = ~k;
  endtask
endmodule // hfm_engine_model

//--- test/hfm_top_tb.sv
// Self-checking bench for the two-controller HDLC FIFO and mapping block.
// Assumes the engine stand-in and host access through the register port.
`timescale 1ns/100ps
module hfm_top_tb import hfm_pkg::*;;
  logic mclk, rst, reg_wr, reg_rd, int_n, sel, stall, slot_is_fdl, slot_is_sa;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [4:0] slot_chan;
  logic [2:0] slot_bit, slot_sa_idx;
  logic [1:0] tx_take, rx_take, tx_v, tx_r, rx_v, rx_e, rx_r;
  logic [1:0][7:0] tx_cfg, rx_cfg, tx_d, rx_d;
  logic [1:0][2:0] rx_k;
  int mismatches, check_count;
  // Device and far-side engine
  hfm_top u_hfm_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_n(int_n),
    .slot_chan(slot_chan), .slot_bit(slot_bit), .slot_is_fdl(slot_is_fdl),
    .slot_is_sa(slot_is_sa), .slot_sa_idx(slot_sa_idx), .tx_take(tx_take), .rx_take(rx_take),
    .tx_config(tx_cfg), .rx_config(rx_cfg), .tx_byte_valid(tx_v), .tx_byte_data(tx_d),
    .tx_byte_ready(tx_r), .rx_byte_valid(rx_v), .rx_byte_data(rx_d), .rx_byte_end(rx_e),
    .rx_end_code(rx_k), .rx_byte_ready(rx_r));
  hfm_engine_model u_hfm_engine_model (.mclk(mclk), .stall(stall), .tx_byte_valid(tx_v),
    .tx_byte_data(tx_d), .tx_byte_ready(tx_r), .rx_byte_valid(rx_v), .rx_byte_data(rx_d),
    .rx_byte_end(rx_e), .rx_end_code(rx_k), .rx_byte_ready(rx_r));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [4:0] o, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = {sel, o};
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  // Register read, data checked the cycle after the strobe
  task automatic rc(input logic [4:0] o, input logic [7:0] m, input logic [7:0] e,
                    input string s);
    @(negedge mclk);
    reg_addr = {sel, o};
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata & m, e, s);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Slot position in, ownership strobes out one cycle later
  task automatic probe(input logic [4:0] ch, input logic [2:0] bt, input logic [3:0] e);
    @(negedge mclk);
    slot_chan = ch;
    slot_bit = bt;
    @(negedge mclk);
    chk({4'h0, rx_take, tx_take}, {4'h0, e}, "slot ownership");
  endtask
  task automatic test_reset();
    rc(OFS_WM, 8'hFF, 8'h00, "watermark reset");
    rc(OFS_TX_SPACE, 8'hFF, 8'h80, "space after reset");
    rc(OFS_RX_FIFO, 8'hFF, 8'h00, "empty fifo read");
    rc(OFS_RX_PBC, 8'hFF, 8'h80, "empty count");
    rc(5'h1F, 8'hFF, 8'h00, "unmapped read");
    chk({7'h0, int_n}, 8'h01, "irq idle");
  endtask
  task automatic test_tx_mark();
    wr(OFS_WM, 8'h2A);
    rc(OFS_WM, 8'h3F, 8'h2A, "watermark fields");
    wr(OFS_WM, 8'h08);
    rc(OFS_STATUS, 8'h01, 8'h01, "low mark live");
    wr(OFS_MASK, 8'h01);
    idle(3);
    chk({7'h0, int_n}, 8'h00, "low mark irq");
    wr(OFS_MASK, 8'h02);
    idle(3);
    chk({7'h0, int_n}, 8'h01, "masked irq");
    stall = 1'b1;
    for (int i = 0; i < 16; i++) wr(OFS_TX_FIFO, 8'h40 + 8'(i));
    rc(OFS_TX_SPACE, 8'hFF, 8'h70, "space after fill");
    rc(OFS_STATUS, 8'h01, 8'h00, "low mark clear");
    stall = 1'b0;
    idle(40);
    chk(8'(u_hfm_engine_model.tx_seen.size()), 8'h10, "tx count");
    for (int i = 0; i < 16; i++) begin
      chk(u_hfm_engine_model.tx_seen[i], 8'h40 + 8'(i), "tx order");
    end
    rc(OFS_TX_SPACE, 8'hFF, 8'h80, "space drained");
    // Controller reset drops a held byte
    stall = 1'b1;
    wr(OFS_TX_FIFO, 8'h5A);
    wr(OFS_TX_CTL, 8'h01);
    rc(OFS_TX_SPACE, 8'hFF, 8'h80, "space after flush");
    stall = 1'b0;
    wr(OFS_MASK, 8'h00);
  endtask
  // Every end code through a two-byte message
  task automatic test_rx_codes();
    for (int k = 1; k <= 4; k++) begin
      u_hfm_engine_model.send(0, 8'h10 + 8'(k), 1'b0, 3'h0);
      u_hfm_engine_model.send(0, 8'h20 + 8'(k), 1'b1, 3'(k));
      idle(8);
      rc(OFS_STATUS, 8'h02, 8'h02, "high mark live");
      rc(OFS_RX_PBC, 8'hFF, 8'h02, "whole message count");
      rc(OFS_RX_FIFO, 8'hFF, 8'h10 + 8'(k), "rx first");
      rc(OFS_RX_FIFO, 8'hFF, 8'h20 + 8'(k), "rx last");
      rc(OFS_INFO, 8'h07, 8'(k), "end code");
      rc(OFS_STATUS, 8'h06, 8'h04, "packet end seen");
      rc(OFS_STATUS, 8'h04, 8'h00, "packet end cleared");
    end
  endtask
  task automatic test_rx_partial();
    for (int i = 0; i < 3; i++) u_hfm_engine_model.send(0, 8'h60 + 8'(i), 1'b0, 3'h0);
    idle(8);
    rc(OFS_RX_PBC, 8'hFF, 8'h83, "open packet count");
    for (int i = 0; i < 3; i++) rc(OFS_RX_FIFO, 8'hFF, 8'h60 + 8'(i), "rx open");
    rc(OFS_INFO, 8'h07, 8'h00, "running code");
    u_hfm_engine_model.send(0, 8'h7E, 1'b1, 3'h1);
    idle(8);
    rc(OFS_RX_PBC, 8'hFF, 8'h01, "closing count");
    rc(OFS_RX_FIFO, 8'hFF, 8'h7E, "rx close");
    rc(OFS_INFO, 8'h07, 8'h01, "good code");
  endtask
  // Channel and bit ownership in both directions, facility link ownership on transmit
  task automatic test_mapping();
    wr(OFS_RX_CTL, 8'h06);
    wr({GRP_RX_CS, 2'h1}, 8'h08);
    wr(OFS_RX_BS, 8'h20);
    sel = 1'b1;
    wr(OFS_TX_CTL, 8'h06);
    wr({GRP_TX_CS, 2'h3}, 8'h80);
    wr(OFS_TX_BS, 8'hFF);
    probe(5'h0B, 3'h5, 4'b0100);
    chk(rx_cfg[0], 8'h06, "rx config out");
    chk(tx_cfg[1], 8'h06, "tx config out");
    probe(5'h0B, 3'h4, 4'b0000);
    probe(5'h0A, 3'h5, 4'b0000);
    probe(5'h1F, 3'h0, 4'b0010);
    probe(5'h1F, 3'h7, 4'b0010);
    wr(OFS_TX_CTL, 8'h02);
    slot_is_fdl = 1'b1;
    probe(5'h00, 3'h0, 4'b0010);
    slot_is_fdl = 1'b0;
    probe(5'h00, 3'h0, 4'b0000);
    // Sa mode picks bits by Sa index
    wr(OFS_TX_BS, 8'h04);
    wr(OFS_TX_CTL, 8'h04);
    slot_is_sa = 1'b1;
    slot_sa_idx = 3'h2;
    probe(5'h00, 3'h0, 4'b0010);
    slot_sa_idx = 3'h3;
    probe(5'h00, 3'h0, 4'b0000);
    slot_is_sa = 1'b0;
    sel = 1'b0;
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (6000) @(posedge mclk);
    mismatches++;
    stop_test();
  end
  // Main sequence
  initial begin
    {rst, reg_wr, reg_rd, sel, stall, slot_is_fdl, slot_is_sa} = 7'h40;
    {reg_addr, reg_wdata, slot_chan, slot_bit, slot_sa_idx} = 25'h0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    test_reset();
    test_tx_mark();
    test_rx_codes();
    test_rx_partial();
    test_mapping();
    stop_test();
  end
endmodule // hfm_top_tb
